// ### ecpfs_top.sv
// Parallel-port FIFO service, DMA handshake and run-length expander
`timescale 1ns/10ps
`include "ecpfs_consts.svh"

// How it works
// - Count byte n repeats next byte n+1 times
// - Control lines open-collector in mode 000 only
// - Disable bit set blocks DMA and service interrupts
// - Clearing disable with condition true interrupts at once
// - Interrupt is brief low pulse, then released
// - Terminal count interrupts and sets disable bit
// - Forward PIO interrupts on enough free space
// - Reverse PIO interrupts on enough stored bytes
// - Fault fall or enable clear with fault interrupts
// - Acknowledge rising edge interrupts when enabled
// - Effective threshold is field plus one
// - Threshold sixteen behaves as fifteen
// - Disable bit set after reset, FIFO only in FIFO modes
// - Request at most 32 cycles, then 350 ns gap
// - DMA acknowledge selects FIFO regardless of address
// - Reverse DMA requests while FIFO holds data
// - Last byte drops request on acknowledge or read
// - Request returns with data, after terminal count re-enable
// - Free-space trigger is 16 minus threshold
module ecpfs_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Host I/O cycle, synchronous to clk_i
  input wire logic [10:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_read_strobe_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  // Host DMA handshake
  input wire logic dma_acknowledge_in_i,
  input wire logic terminal_count_i,
  output logic dma_request_out_o,
  // Control bits from the port's control registers
  input wire logic [2:0] port_mode_i,
  input wire logic direction_i,
  input wire logic [3:0] threshold_field_i,
  input wire logic dma_enable_bit_i,
  input wire logic error_irq_enable_low_i,
  input wire logic acknowledge_irq_enable_i,
  input wire logic svc_disable_wr_i,
  input wire logic svc_disable_wdata_i,
  output logic service_irq_disable_o,
  // Interrupt pin, open drain
  output logic port_irq_out_o,
  output logic port_irq_out_oe_n_o,
  // Peripheral status pins, asynchronous
  input wire logic peripheral_fault_in_n_i,
  input wire logic peripheral_acknowledge_in_n_i,
  // Control line levels wanted and the driven pins
  input wire logic strobe_val_i,
  input wire logic auto_feed_val_i,
  input wire logic init_val_i,
  input wire logic select_in_val_i,
  output logic [3:0] ctl_line_o,
  output logic [3:0] ctl_line_oe_n_o,
  // Forward bytes to the link engine, bit 8 marks a command
  output logic fwd_valid_o,
  output logic [8:0] fwd_word_o,
  input wire logic fwd_ready_i,
  // Reverse bytes from the link engine
  input wire logic rev_valid_i,
  input wire logic rev_cmd_i,
  input wire logic [7:0] rev_data_i,
  output logic rev_ready_o
);

  // ========================================================
  // State and FIFO wiring
  ecpfs_pkg::ecpfs_state_type st;
  ecpfs_pkg::ecpfs_state_type next_st;
  logic fifo_flush;
  logic fifo_push;
  logic fifo_pop;
  logic [8:0] fifo_wdata;
  logic [8:0] fifo_rdata;
  logic [4:0] fifo_count;
  logic [3:0] ctl_val;
  logic [3:0] next_ctl_oe_n;

  ecpfs_fifo u_fifo
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(fifo_flush),
    .push_i(fifo_push),
    .pop_i(fifo_pop),
    .wdata_i(fifo_wdata),
    .rdata_o(fifo_rdata),
    .count_o(fifo_count)
  );

  // ========================================================
  // Control line driver style, one per line
  assign ctl_val = {select_in_val_i, init_val_i, auto_feed_val_i,
    strobe_val_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_ctl
      // Open collector releases a high level instead of driving it
      assign next_ctl_oe_n[g] = (port_mode_i == `ECPFS_MODE_STD) ?
        ctl_val[g] : 1'b0;
    end
  endgenerate

  // ========================================================
  // Next-state logic
  always_comb
  begin
    logic fifo_on;
    logic xfer_mode;
    logic test_mode;
    logic rev_on;
    logic full;
    logic empty;
    logic [4:0] eff_thr;
    logic [4:0] free_space_trigger;
    logic [4:0] fill_level_trigger;
    logic [4:0] free;
    logic dfifo_wr;
    logic afifo_wr;
    logic dfifo_rd;
    logic rev_take;
    logic dma_cycle;
    logic ack_rise;
    logic terminal_hit;
    logic want;
    logic last;
    logic pio_now;
    logic err_event;
    logic ack_event;
    next_st = st;
    fifo_on = 1'b0;
    xfer_mode = 1'b0;
    test_mode = 1'b0;
    rev_on = 1'b0;
    full = 1'b0;
    empty = 1'b0;
    eff_thr = 5'h00;
    free_space_trigger = 5'h00;
    fill_level_trigger = 5'h00;
    free = 5'h00;
    dfifo_wr = 1'b0;
    afifo_wr = 1'b0;
    dfifo_rd = 1'b0;
    rev_take = 1'b0;
    dma_cycle = 1'b0;
    ack_rise = 1'b0;
    terminal_hit = 1'b0;
    want = 1'b0;
    last = 1'b0;
    pio_now = 1'b0;
    err_event = 1'b0;
    ack_event = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_wdata = 9'h000;

    // Mode decode; outside the FIFO modes the FIFO is held flushed
    xfer_mode = (port_mode_i == `ECPFS_MODE_FIFO) ||
      (port_mode_i == `ECPFS_MODE_ECP);
    test_mode = (port_mode_i == `ECPFS_MODE_TEST);
    fifo_on = xfer_mode || test_mode;
    fifo_flush = !fifo_on;
    rev_on = direction_i && (port_mode_i == `ECPFS_MODE_ECP);

    // Thresholds, all taken from the live occupancy count
    full = (fifo_count == `ECPFS_FIFO_DEPTH);
    empty = (fifo_count == 5'h00);
    free = `ECPFS_FIFO_DEPTH - fifo_count;
    if (threshold_field_i == `ECPFS_THR_FIELD_MAX)
      eff_thr = `ECPFS_THR_CAP;
    else
      eff_thr = {1'b0, threshold_field_i} + 5'h01;
    free_space_trigger = `ECPFS_FIFO_DEPTH - eff_thr;
    fill_level_trigger = `ECPFS_FIFO_DEPTH - eff_thr;

    // Host port decode; an acknowledged DMA cycle ignores the address
    dfifo_wr = host_wr_i && (dma_acknowledge_in_i ||
      host_addr_i == `ECPFS_ADDR_DFIFO);
    afifo_wr = host_wr_i && !dma_acknowledge_in_i &&
      host_addr_i == `ECPFS_ADDR_AFIFO &&
      port_mode_i == `ECPFS_MODE_ECP;
    dfifo_rd = host_read_strobe_i && (dma_acknowledge_in_i ||
      host_addr_i == `ECPFS_ADDR_DFIFO);

    // Host side of the FIFO: fill forward, drain reverse, both in test
    if (fifo_on && (!direction_i || test_mode))
    begin
      fifo_push = (dfifo_wr || afifo_wr) && !full;
      fifo_wdata = {afifo_wr, host_wdata_i};
    end
    if (fifo_on && (direction_i || test_mode))
    begin
      fifo_pop = dfifo_rd && !empty;
      if (dfifo_rd)
        next_st.host_rdata = fifo_rdata[7:0];
    end

    // Forward output stage toward the link engine
    if (!xfer_mode || direction_i)
      next_st.fwd_valid = 1'b0;
    else
    begin
      if (fwd_ready_i)
        next_st.fwd_valid = 1'b0;
      if ((!st.fwd_valid || fwd_ready_i) && !empty)
      begin
        fifo_pop = 1'b1;
        next_st.fwd_valid = 1'b1;
        next_st.fwd_word = fifo_rdata;
      end
    end

    // Run-length expander on reverse data
    rev_take = rev_valid_i && st.rev_ready;
    if (!rev_on)
      next_st.run_state = ecpfs_pkg::ecpfs_run_idle;
    else
    begin
      case (st.run_state)
        ecpfs_pkg::ecpfs_run_idle:
        begin
          // Channel addresses are dropped; counts are stored in run_count
          if (rev_take && rev_cmd_i && !rev_data_i[7])
          begin
            next_st.run_count = rev_data_i[6:0];
            next_st.run_state = ecpfs_pkg::ecpfs_run_wait_byte;
          end
          else if (rev_take && !rev_cmd_i)
          begin
            next_st.run_byte = rev_data_i;
            next_st.run_left = 7'h00;
            next_st.run_state = ecpfs_pkg::ecpfs_run_expand;
          end
        end
        ecpfs_pkg::ecpfs_run_wait_byte:
        begin
          // A second count replaces the first
          if (rev_take && rev_cmd_i && !rev_data_i[7])
            next_st.run_count = rev_data_i[6:0];
          else if (rev_take && !rev_cmd_i)
          begin
            next_st.run_byte = rev_data_i;
            next_st.run_left = st.run_count;
            next_st.run_state = ecpfs_pkg::ecpfs_run_expand;
          end
        end
        ecpfs_pkg::ecpfs_run_expand:
        begin
          // One copy per cycle while there is room: count plus one total
          if (!full)
          begin
            fifo_push = 1'b1;
            fifo_wdata = {1'b0, st.run_byte};
            if (st.run_left == 7'h00)
              next_st.run_state = ecpfs_pkg::ecpfs_run_idle;
            else
              next_st.run_left = st.run_left - 7'h01;
          end
        end
        default:
          next_st.run_state = ecpfs_pkg::ecpfs_run_idle;
      endcase
    end
    next_st.rev_ready = rev_on &&
      (next_st.run_state != ecpfs_pkg::ecpfs_run_expand);

    // Terminal count sets the disable bit; the set beats a host clear
    ack_rise = dma_acknowledge_in_i && !st.dma_ack_d;
    dma_cycle = dma_acknowledge_in_i && (host_wr_i || host_read_strobe_i);
    terminal_hit = !st.service_irq_disable && dma_enable_bit_i &&
      dma_acknowledge_in_i && terminal_count_i;
    if (svc_disable_wr_i)
      next_st.service_irq_disable = svc_disable_wdata_i;
    if (terminal_hit)
      next_st.service_irq_disable = 1'b1;

    // Burst limit and the gap the acknowledge must stay low for
    if (!st.dma_request_out)
      next_st.burst = 6'h00;
    else if (dma_cycle)
    begin
      if (st.burst + 6'h01 == `ECPFS_BURST_MAX)
      begin
        next_st.burst = 6'h00;
        next_st.holdoff_on = 1'b1;
        next_st.holdoff = 6'h00;
      end
      else
        next_st.burst = st.burst + 6'h01;
    end
    if (st.holdoff_on)
    begin
      if (dma_acknowledge_in_i)
        next_st.holdoff = 6'h00;
      else if (st.holdoff + 6'h01 >= 6'(`ECPFS_HOLDOFF_CYC))
        next_st.holdoff_on = 1'b0;
      else
        next_st.holdoff = st.holdoff + 6'h01;
    end

    // Request level; reverse needs data, forward needs room
    want = direction_i ? !empty : !full;
    last = direction_i ? (fifo_count == 5'h01) : (free == 5'h01);
    next_st.dma_request_out = !next_st.service_irq_disable &&
      dma_enable_bit_i && xfer_mode && want &&
      !next_st.holdoff_on && !terminal_hit &&
      !(last && (ack_rise || (host_read_strobe_i && direction_i)));

    // Programmed I/O service condition as a level
    if (direction_i)
      pio_now = (fifo_count >= fill_level_trigger);
    else
      pio_now = (free >= free_space_trigger);
    pio_now = pio_now && !next_st.service_irq_disable &&
      !dma_enable_bit_i && xfer_mode;
    next_st.pio_cond = pio_now;

    // Peripheral pins pass two flip-flops before use
    next_st.fault_meta = peripheral_fault_in_n_i;
    next_st.fault_sync = st.fault_meta;
    next_st.fault_n_d = st.fault_sync;
    next_st.ack_meta = peripheral_acknowledge_in_n_i;
    next_st.ack_sync = st.ack_meta;
    next_st.ack_n_d = st.ack_sync;
    next_st.err_en_n_d = error_irq_enable_low_i;
    next_st.dma_ack_d = dma_acknowledge_in_i;
    err_event = !error_irq_enable_low_i && !st.fault_sync &&
      (st.fault_n_d || st.err_en_n_d);
    ack_event = acknowledge_irq_enable_i && !st.ack_n_d &&
      st.ack_sync;

    // Each event restarts a short low pulse, then the pin is released
    if ((pio_now && !st.pio_cond) || terminal_hit || err_event ||
      ack_event)
      next_st.irq_timer = 4'(`ECPFS_IRQ_PULSE_CYC);
    else if (st.irq_timer != 4'h0)
      next_st.irq_timer = st.irq_timer - 4'h1;
    next_st.irq_oe_n = (next_st.irq_timer == 4'h0);
    next_st.irq_level = 1'b0;

    // Control lines follow the wanted levels
    next_st.ctl_out = ctl_val;
    next_st.ctl_oe_n = next_ctl_oe_n;
  end

  // ========================================================
  // State register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= '0;
      st.service_irq_disable <= `ECPFS_SVC_DIS_RST;
      st.run_state <= ecpfs_pkg::ecpfs_run_idle;
      st.irq_oe_n <= 1'b1;
      st.ctl_oe_n <= 4'hF;
      st.fault_meta <= 1'b1;
      st.fault_sync <= 1'b1;
      st.fault_n_d <= 1'b1;
      st.ack_meta <= 1'b1;
      st.ack_sync <= 1'b1;
      st.ack_n_d <= 1'b1;
      st.err_en_n_d <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ========================================================
  // Outputs, each a field of the state register
  assign host_rdata_o = st.host_rdata;
  assign dma_request_out_o = st.dma_request_out;
  assign service_irq_disable_o = st.service_irq_disable;
  assign port_irq_out_o = st.irq_level;
  assign port_irq_out_oe_n_o = st.irq_oe_n;
  assign ctl_line_o = st.ctl_out;
  assign ctl_line_oe_n_o = st.ctl_oe_n;
  assign fwd_valid_o = st.fwd_valid;
  assign fwd_word_o = st.fwd_word;
  assign rev_ready_o = st.rev_ready;

endmodule

// ### ecpfs_consts.svh
// Constants for the parallel-port FIFO service and DMA block
`ifndef ECPFS_CONSTS_SVH
`define ECPFS_CONSTS_SVH

// ==========================================================
// Host-visible FIFO port addresses
`define ECPFS_ADDR_AFIFO 11'h000
`define ECPFS_ADDR_DFIFO 11'h400

// ==========================================================
// Port modes
`define ECPFS_MODE_STD 3'h0
`define ECPFS_MODE_FIFO 3'h2
`define ECPFS_MODE_ECP 3'h3
`define ECPFS_MODE_TEST 3'h6

// ==========================================================
// FIFO geometry and threshold limits
`define ECPFS_FIFO_DEPTH 5'h10
`define ECPFS_THR_CAP 5'h0F
`define ECPFS_THR_FIELD_MAX 4'hF

// ==========================================================
// Reset values
`define ECPFS_SVC_DIS_RST 1'b1

// ==========================================================
// DMA burst limit and timing
`define ECPFS_BURST_MAX 6'h20
`define ECPFS_CLK_PERIOD_NS 10
`define ECPFS_HOLDOFF_NS 350
`define ECPFS_HOLDOFF_CYC \
  ((`ECPFS_HOLDOFF_NS + `ECPFS_CLK_PERIOD_NS - 1) / `ECPFS_CLK_PERIOD_NS)
`define ECPFS_IRQ_PULSE_NS 100
`define ECPFS_IRQ_PULSE_CYC (`ECPFS_IRQ_PULSE_NS / `ECPFS_CLK_PERIOD_NS)

`endif

// ### ecpfs_pkg.sv
// Types for the parallel-port FIFO service and DMA block
package ecpfs_pkg;

  // ========================================================
  // Run-length expander states
  typedef enum logic [1:0]
  {
    ecpfs_run_idle,
    ecpfs_run_wait_byte,
    ecpfs_run_expand
  } ecpfs_run_state_type;

  // ========================================================
  // Whole state of the top module
  typedef struct packed
  {
    logic service_irq_disable;
    logic dma_request_out;
    logic [3:0] ctl_out;
    logic [3:0] ctl_oe_n;
    logic irq_level;
    logic irq_oe_n;
    logic [3:0] irq_timer;
    logic [7:0] host_rdata;
    logic fwd_valid;
    logic [8:0] fwd_word;
    logic rev_ready;
    ecpfs_run_state_type run_state;
    logic [6:0] run_left;
    logic [6:0] run_count;
    logic [7:0] run_byte;
    logic [5:0] burst;
    logic [5:0] holdoff;
    logic holdoff_on;
    logic pio_cond;
    logic fault_meta;
    logic fault_sync;
    logic fault_n_d;
    logic ack_meta;
    logic ack_sync;
    logic ack_n_d;
    logic err_en_n_d;
    logic dma_ack_d;
  } ecpfs_state_type;

endpackage

// ### ecpfs_fifo.sv
// Sixteen-entry byte FIFO with a command flag per entry
`timescale 1ns/10ps
`include "ecpfs_consts.svh"

module ecpfs_fifo
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic pop_i,
  // Data
  input wire logic [8:0] wdata_i,
  output logic [8:0] rdata_o,
  output logic [4:0] count_o
);

  // ========================================================
  // Storage and pointers
  logic [8:0] mem [16];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] count;
  logic do_push;
  logic do_pop;

  // Caller guards push against full and pop against empty
  assign do_push = push_i && !flush_i;
  assign do_pop = pop_i && !flush_i;
  assign rdata_o = mem[rd_ptr];
  assign count_o = count;

  // Pointers and synchronous occupancy count
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
    end
    else if (flush_i)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 4'h1;
      if (do_pop)
        rd_ptr <= rd_ptr + 4'h1;
      if (do_push && !do_pop)
        count <= count + 5'h01;
      else if (do_pop && !do_push)
        count <= count - 5'h01;
    end
  end

  // One write port per entry
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : gen_entry
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          mem[g] <= 9'h000;
        else if (do_push && (wr_ptr == 4'(g)))
          mem[g] <= wdata_i;
      end
    end
  endgenerate

endmodule

// ### ecpfs_top_properties.sv
// Checker for the FIFO service and DMA block
`timescale 1ns/10ps
module ecpfs_top_properties
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Inputs watched
  input wire logic [2:0] port_mode_i,
  input wire logic strobe_val_i,
  input wire logic dma_acknowledge_in_i,
  input wire logic terminal_count_i,
  input wire logic host_read_strobe_i,
  input wire logic dma_enable_bit_i,
  input wire logic error_irq_enable_low_i,
  input wire logic acknowledge_irq_enable_i,
  input wire logic peripheral_fault_in_n_i,
  input wire logic peripheral_acknowledge_in_n_i,
  // Outputs watched
  input wire logic dma_request_out_o,
  input wire logic service_irq_disable_o,
  input wire logic port_irq_out_o,
  input wire logic port_irq_out_oe_n_o,
  input wire logic [3:0] ctl_line_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] low_cnt;
  logic [7:0] dma_cnt;
  // ========================================================
  // Pulse length and DMA cycles within one request
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      low_cnt <= 8'h00;
      dma_cnt <= 8'h00;
    end
    else
    begin
      low_cnt <= port_irq_out_oe_n_o ? 8'h00 : low_cnt + 8'h01;
      // Cleared on a dropped request, as the burst limit restarts
      dma_cnt <= !dma_request_out_o ? 8'h00 :
        dma_cnt + {7'h00, dma_acknowledge_in_i && host_read_strobe_i};
    end
  end
  // ========================================================
  // Steps of a terminal count and of an interrupt pulse
  sequence tc_hit;
    dma_acknowledge_in_i && terminal_count_i && dma_enable_bit_i &&
      !service_irq_disable_o;
  endsequence
  sequence irq_low;
    !port_irq_out_oe_n_o && !port_irq_out_o;
  endsequence
  chk_tc_disable: assert property (tc_hit |=>
    service_irq_disable_o && !dma_request_out_o) else $error("tc stop");
  chk_tc_irq: assert property (tc_hit |=> irq_low)
    else $error("tc irq");
  chk_disable_no_req: assert property (
    service_irq_disable_o && $past(service_irq_disable_o) |->
    !dma_request_out_o) else $error("req while disabled");
  chk_dma_off: assert property (
    !dma_enable_bit_i |=> !dma_request_out_o) else $error("req no dma");
  chk_push_pull: assert property (
    port_mode_i != 3'h0 |=> ctl_line_oe_n_o == 4'h0) else $error("oe");
  chk_open_coll: assert property (port_mode_i == 3'h0 |=>
    ctl_line_oe_n_o[0] == $past(strobe_val_i)) else $error("oc");
  chk_pulse_len: assert property (
    $rose(port_irq_out_oe_n_o) |-> low_cnt >= 8'h0A) else $error("short");
  chk_pulse_brief: assert property (low_cnt <= 8'h28)
    else $error("irq stuck");
  chk_fault_irq: assert property ($fell(peripheral_fault_in_n_i) &&
    !error_irq_enable_low_i |-> ##[1:8] irq_low) else $error("fault");
  chk_ack_irq: assert property (
    $rose(peripheral_acknowledge_in_n_i) && acknowledge_irq_enable_i |->
    ##[1:8] irq_low) else $error("ack irq");
  chk_burst_cap: assert property (
    dma_request_out_o |-> dma_cnt <= 8'h20) else $error("burst");
endmodule

bind ecpfs_top ecpfs_top_properties i_props (.*);

// ### ecpfs_dma_host_model.sv
// Host DMA controller model answering the block's requests
`timescale 1ns/10ps
module ecpfs_dma_host_model
(
  // Clock and bench control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [31:0] tc_at_i,
  // Block side
  input wire logic req_i,
  input wire logic [7:0] rdata_i,
  output logic ack_o,
  output logic rd_o,
  output logic tc_o,
  // Results
  output int n_o,
  output logic [7:0] last_o
);
  // One read per request seen; the idle cycle lets a burst end
  initial
  begin
    {ack_o, rd_o, tc_o} = 3'h0;
    n_o = 0;
    last_o = 8'h00;
    forever
    begin
      @(posedge clk_i);
      #1;
      if (en_i && req_i)
      begin
        ack_o = 1'b1;
        rd_o = 1'b1;
        tc_o = (n_o + 1 == tc_at_i);
        @(posedge clk_i);
        #1;
        {ack_o, rd_o, tc_o} = 3'h0;
        n_o++;
        last_o = rdata_i;
      end
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench for the FIFO service and DMA block
`timescale 1ns/10ps
module testbench;
  logic clk_i, arst_n_i, host_wr_i, tb_rd, m_rd, m_en, seen;
  logic [10:0] host_addr_i;
  logic [7:0] host_wdata_i, host_rdata_o, rev_data_i, m_last, d;
  logic [2:0] port_mode_i;
  logic [3:0] threshold_field_i, ctl_line_o, ctl_line_oe_n_o;
  logic direction_i, dma_enable_bit_i, error_irq_enable_low_i;
  logic acknowledge_irq_enable_i, svc_disable_wr_i, svc_disable_wdata_i;
  logic service_irq_disable_o, port_irq_out_o, port_irq_out_oe_n_o;
  logic peripheral_fault_in_n_i, peripheral_acknowledge_in_n_i;
  logic strobe_val_i, auto_feed_val_i, init_val_i, select_in_val_i;
  logic fwd_valid_o, fwd_ready_i, rev_valid_i, rev_cmd_i, rev_ready_o;
  logic dma_acknowledge_in_i, terminal_count_i, dma_request_out_o;
  logic [8:0] fwd_word_o;
  wire logic host_read_strobe_i;
  int error_cnt, num_checks, m_n, tc_at, i;
  assign host_read_strobe_i = tb_rd | m_rd;
  ecpfs_top i_dut (.*);
  ecpfs_dma_host_model i_host (.clk_i(clk_i), .en_i(m_en),
    .tc_at_i(tc_at), .req_i(dma_request_out_o), .rdata_i(host_rdata_o),
    .ack_o(dma_acknowledge_in_i), .rd_o(m_rd), .tc_o(terminal_count_i),
    .n_o(m_n), .last_o(m_last));
  // ========================================================
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ========================================================
  // Access tasks; inputs change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string s, input logic [8:0] e,
    input logic [8:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      error_cnt++;
    end
  endtask
  task automatic host_wr(input logic [10:0] a, input logic [7:0] v);
    tick(1);
    host_addr_i = a;
    host_wdata_i = v;
    host_wr_i = 1'b1;
    tick(1);
    host_wr_i = 1'b0;
  endtask
  task automatic host_rd(output logic [7:0] v);
    tick(1);
    host_addr_i = 11'h400;
    tb_rd = 1'b1;
    tick(1);
    tb_rd = 1'b0;
    v = host_rdata_o;
  endtask
  task automatic svc_wr(input logic v);
    tick(1);
    svc_disable_wdata_i = v;
    svc_disable_wr_i = 1'b1;
    tick(1);
    svc_disable_wr_i = 1'b0;
  endtask
  // Held until an edge that sees ready high; ready is read off the edge
  task automatic rev_send(input logic c, input logic [7:0] v);
    tick(1);
    rev_valid_i = 1'b1;
    rev_cmd_i = c;
    rev_data_i = v;
    while (rev_ready_o !== 1'b1) tick(1);
    tick(1);
    rev_valid_i = 1'b0;
  endtask
  task automatic irq_in(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      tick(1);
      if (port_irq_out_oe_n_o === 1'b0) seen = 1'b1;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ========================================================
  // Tests
  initial
  begin
    {arst_n_i, host_wr_i, tb_rd, m_en, host_addr_i, host_wdata_i} = '0;
    {rev_data_i, port_mode_i, threshold_field_i, direction_i} = '0;
    {dma_enable_bit_i, acknowledge_irq_enable_i, svc_disable_wr_i} = '0;
    {svc_disable_wdata_i, fwd_ready_i, rev_valid_i, rev_cmd_i} = '0;
    {error_irq_enable_low_i, peripheral_fault_in_n_i} = 2'h3;
    peripheral_acknowledge_in_n_i = 1'b1;
    {select_in_val_i, init_val_i, auto_feed_val_i, strobe_val_i} = 4'hF;
    {error_cnt, num_checks, tc_at} = '0;
    tick(10);
    arst_n_i = 1'b1;
    tick(2);
    chk("disable", 9'h001, service_irq_disable_o);
    chk("req", 9'h000, dma_request_out_o);
    chk("ctl oe", 9'h00F, ctl_line_oe_n_o);
    $display("test reset done");
    {select_in_val_i, init_val_i, auto_feed_val_i, strobe_val_i} = 4'h5;
    tick(2);
    chk("ctl oc", 9'h005, ctl_line_oe_n_o);
    for (i = 1; i < 8; i++)
    begin
      port_mode_i = i[2:0];
      tick(2);
      chk("ctl oe", 9'h000, ctl_line_oe_n_o);
      chk("ctl", 9'h005, ctl_line_o);
    end
    $display("test drivers done");
    port_mode_i = 3'h3;
    irq_in(20);
    chk("irq held", 9'h000, seen);
    svc_wr(1'b0);
    irq_in(4);
    chk("irq clear", 9'h001, seen);
    chk("irq level", 9'h000, port_irq_out_o);
    irq_in(12);
    chk("irq off", 9'h001, port_irq_out_oe_n_o);
    host_wr(11'h000, 8'h03);
    host_wr(11'h400, 8'h77);
    chk("fwd cmd", 9'h103, fwd_word_o);
    chk("fwd valid", 9'h001, fwd_valid_o);
    fwd_ready_i = 1'b1;
    tick(1);
    fwd_ready_i = 1'b0;
    tick(2);
    chk("fwd data", 9'h077, fwd_word_o);
    fwd_ready_i = 1'b1;
    $display("test forward done");
    svc_wr(1'b1);
    port_mode_i = 3'h1;
    tick(1);
    direction_i = 1'b1;
    threshold_field_i = 4'h3;
    tick(1);
    port_mode_i = 3'h3;
    svc_wr(1'b0);
    rev_send(1'b1, 8'h0A);
    rev_send(1'b0, 8'h3C);
    irq_in(20);
    chk("irq 11", 9'h000, seen);
    rev_send(1'b0, 8'h3C);
    irq_in(6);
    chk("irq 12", 9'h001, seen);
    for (i = 0; i < 12; i++)
    begin
      host_rd(d);
      chk("rle byte", 9'h03C, d);
    end
    svc_wr(1'b1);
    threshold_field_i = 4'hF;
    svc_wr(1'b0);
    irq_in(8);
    chk("irq empty", 9'h000, seen);
    rev_send(1'b0, 8'h11);
    irq_in(6);
    chk("irq one", 9'h001, seen);
    host_rd(d);
    chk("byte", 9'h011, d);
    $display("test reverse done");
    svc_wr(1'b1);
    dma_enable_bit_i = 1'b1;
    m_en = 1'b1;
    host_addr_i = 11'h000;
    svc_wr(1'b0);
    rev_send(1'b1, 8'h7F);
    rev_send(1'b0, 8'hC3);
    rev_send(1'b0, 8'h99);
    for (i = 0; i < 3000 && m_n < 129; i++) tick(1);
    chk("dma count", 9'h081, m_n[8:0]);
    chk("dma last", 9'h099, m_last);
    tick(4);
    chk("req empty", 9'h000, dma_request_out_o);
    tc_at = 132;
    rev_send(1'b1, 8'h04);
    rev_send(1'b0, 8'h55);
    for (i = 0; i < 500 && m_n < 132; i++) tick(1);
    tick(2);
    chk("irq tc", 9'h000, port_irq_out_oe_n_o);
    chk("svc set", 9'h001, service_irq_disable_o);
    tick(20);
    chk("tc stop", 9'h084, m_n[8:0]);
    svc_wr(1'b0);
    for (i = 0; i < 500 && m_n < 134; i++) tick(1);
    chk("resume", 9'h086, m_n[8:0]);
    m_en = 1'b0;
    $display("test dma done");
    dma_enable_bit_i = 1'b0;
    svc_wr(1'b1);
    error_irq_enable_low_i = 1'b0;
    irq_in(15);
    peripheral_fault_in_n_i = 1'b0;
    irq_in(8);
    chk("fault irq", 9'h001, seen);
    error_irq_enable_low_i = 1'b1;
    irq_in(15);
    error_irq_enable_low_i = 1'b0;
    irq_in(15);
    chk("fault en irq", 9'h001, seen);
    acknowledge_irq_enable_i = 1'b1;
    peripheral_acknowledge_in_n_i = 1'b0;
    irq_in(15);
    chk("ack fall", 9'h000, seen);
    peripheral_acknowledge_in_n_i = 1'b1;
    irq_in(8);
    chk("ack irq", 9'h001, seen);
    $display("test status done");
    end_of_test;
  end
  // Watchdog: the tests need about 700 cycles
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test;
  end
endmodule
